//--- one_bit_ctrl_defines.svh
// Constants for the one-bit control processor execution logic
`ifndef ONE_BIT_CTRL_DEFINES_SVH
`define ONE_BIT_CTRL_DEFINES_SVH

// ============================================================
// Opcode encodings (4-bit instruction field)
`define OPC_FLAG_LOW       4'h0
`define OPC_LOAD_BIT       4'h1
`define OPC_LOAD_INVERTED  4'h2
`define OPC_AND_BIT        4'h3
`define OPC_AND_INVERTED   4'h4
`define OPC_OR_BIT         4'h5
`define OPC_OR_INVERTED    4'h6
`define OPC_XNOR_BIT       4'h7
`define OPC_STORE_BIT      4'h8
`define OPC_STORE_INVERTED 4'h9
`define OPC_INPUT_GATE     4'ha
`define OPC_OUTPUT_GATE    4'hb
`define OPC_BRANCH_OP      4'hc
`define OPC_RETURN_OP      4'hd
`define OPC_SKIP_ON_ZERO   4'he
`define OPC_FLAG_HIGH      4'hf

// ============================================================
// Reset values of the one-bit state
`define RST_RESULT_BIT       1'b0
`define RST_OUTPUT_GATE_FLAG 1'b0
`define RST_INPUT_GATE_FLAG  1'b0
`define RST_SKIP_PENDING     1'b0

`endif

//--- one_bit_ctrl_pkg.sv
// Types shared by the one-bit control processor execution logic
`include "one_bit_ctrl_defines.svh"

package one_bit_ctrl_pkg;

  // ============================================================
  // Instruction opcodes
  typedef enum logic [3:0] {
    FLAG_LOW       = `OPC_FLAG_LOW,
    LOAD_BIT       = `OPC_LOAD_BIT,
    LOAD_INVERTED  = `OPC_LOAD_INVERTED,
    AND_BIT        = `OPC_AND_BIT,
    AND_INVERTED   = `OPC_AND_INVERTED,
    OR_BIT         = `OPC_OR_BIT,
    OR_INVERTED    = `OPC_OR_INVERTED,
    XNOR_BIT       = `OPC_XNOR_BIT,
    STORE_BIT      = `OPC_STORE_BIT,
    STORE_INVERTED = `OPC_STORE_INVERTED,
    INPUT_GATE     = `OPC_INPUT_GATE,
    OUTPUT_GATE    = `OPC_OUTPUT_GATE,
    BRANCH_OP      = `OPC_BRANCH_OP,
    RETURN_OP      = `OPC_RETURN_OP,
    SKIP_ON_ZERO   = `OPC_SKIP_ON_ZERO,
    FLAG_HIGH      = `OPC_FLAG_HIGH
  } opcode_t;

  // One fetched instruction with the addressed input bit
  typedef struct packed {
    opcode_t op;
    logic    data;
  } instr_t;

  // Whole state of the execution logic
  typedef struct packed {
    logic result_bit;
    logic output_gate_flag;
    logic input_gate_flag;
    logic skip_pending;
    logic store_pulse;
    logic store_data;
    logic branch_pulse;
    logic return_pulse;
    logic flag_low_pulse;
    logic flag_high_pulse;
  } exec_state_t;

endpackage : one_bit_ctrl_pkg

//--- one_bit_logic_unit.sv
// Combinational one-bit logic unit producing the next result bit
module one_bit_logic_unit (
  input  one_bit_ctrl_pkg::opcode_t op_i,
  input  wire logic                 result_i,
  input  wire logic                 data_i,
  input  wire logic                 input_gate_i,
  output logic                      result_o
);
  import one_bit_ctrl_pkg::*;

  logic gated_data;

  // ============================================================
  // Operand gating and logic functions
  always_comb begin
    // RQ8 input gate admits data
    gated_data = data_i & input_gate_i;
    result_o   = result_i;
    case (op_i)
      // RQ1 load replaces result
      LOAD_BIT:      result_o = gated_data;
      LOAD_INVERTED: result_o = ~gated_data;
      AND_BIT:       result_o = result_i & gated_data;
      // RQ10 inverted operand combine
      AND_INVERTED:  result_o = result_i & ~gated_data;
      OR_BIT:        result_o = result_i | gated_data;
      // RQ10 inverted operand combine
      OR_INVERTED:   result_o = result_i | ~gated_data;
      XNOR_BIT:      result_o = ~(result_i ^ gated_data);
      default:       result_o = result_i;
    endcase
  end

endmodule : one_bit_logic_unit

//--- one_bit_enable_and_flow_logic.sv
// Execution logic of a one-bit control processor
`include "one_bit_ctrl_defines.svh"

// Contract
// RQ1 - Load copies the addressed input into the result bit.
// RQ2 - Output gate load copies the addressed source into the output gate flag.
// RQ3 - Gate flag zero: instructions still step, but nothing written changes.
// RQ4 - Store inverted writes complement of result; result bit stays unchanged.
// RQ5 - Store writes result bit unchanged when output gate flag is one.
// RQ6 - Skip on zero ignores the next instruction when result bit is zero.
// RQ7 - Outside sequencer reloads program counter on branch; else it wraps.
// RQ8 - Input gate flag one admits input data into result logic.
// RQ9 - No store pulse while the output gate flag holds zero.
// RQ10 - Inverted and/or combine result with the complement of the input.
module one_bit_enable_and_flow_logic (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  one_bit_ctrl_pkg::instr_t instr_i,
  output logic                     result_bit_o,
  output logic                     output_gate_flag_o,
  output logic                     input_gate_flag_o,
  output logic                     skip_pending_o,
  output logic                     store_pulse_o,
  output logic                     store_data_o,
  output logic                     branch_pulse_o,
  output logic                     return_pulse_o,
  output logic                     flag_low_pulse_o,
  output logic                     flag_high_pulse_o
);
  import one_bit_ctrl_pkg::*;

  exec_state_t state_reg;
  exec_state_t state_next;
  logic        unit_result;
  logic        executing;

  // ============================================================
  // Logic unit
  one_bit_logic_unit u_logic (
    .op_i         (instr_i.op),
    .result_i     (state_reg.result_bit),
    .data_i       (instr_i.data),
    .input_gate_i (state_reg.input_gate_flag),
    .result_o     (unit_result)
  );

  // ============================================================
  // Next-state decode
  always_comb begin
    state_next                 = state_reg;
    // Pulses last one cycle only
    state_next.store_pulse     = 1'b0;
    state_next.branch_pulse    = 1'b0;
    state_next.return_pulse    = 1'b0;
    state_next.flag_low_pulse  = 1'b0;
    state_next.flag_high_pulse = 1'b0;
    state_next.skip_pending    = 1'b0;
    // RQ6 skipped slot has no effect
    executing                  = ~state_reg.skip_pending;
    if (executing) begin
      state_next.result_bit = unit_result;
      case (instr_i.op)
        STORE_BIT: begin
          // RQ5 store true value
          // RQ3 gated off, no write
          // RQ9 gate suppresses strobe
          state_next.store_pulse = state_reg.output_gate_flag;
          state_next.store_data  = state_reg.result_bit;
        end
        STORE_INVERTED: begin
          // RQ4 store complement only
          state_next.store_pulse = state_reg.output_gate_flag;
          state_next.store_data  = ~state_reg.result_bit;
        end
        INPUT_GATE: begin
          state_next.input_gate_flag = instr_i.data;
        end
        OUTPUT_GATE: begin
          // RQ2 gate load from source
          state_next.output_gate_flag = instr_i.data;
        end
        BRANCH_OP: begin
          // RQ7 sequencer reloads counter
          state_next.branch_pulse = 1'b1;
        end
        RETURN_OP: begin
          // Return also skips the slot after it
          state_next.return_pulse = 1'b1;
          state_next.skip_pending = 1'b1;
        end
        SKIP_ON_ZERO: begin
          // RQ6 arm skip on zero
          state_next.skip_pending = ~state_reg.result_bit;
        end
        FLAG_LOW: begin
          state_next.flag_low_pulse = 1'b1;
        end
        FLAG_HIGH: begin
          state_next.flag_high_pulse = 1'b1;
        end
        default: begin
          state_next.store_data = state_reg.store_data;
        end
      endcase
    end
  end

  // ============================================================
  // State register, synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg                  <= '0;
      state_reg.result_bit       <= `RST_RESULT_BIT;
      state_reg.output_gate_flag <= `RST_OUTPUT_GATE_FLAG;
      state_reg.input_gate_flag  <= `RST_INPUT_GATE_FLAG;
      state_reg.skip_pending     <= `RST_SKIP_PENDING;
    end else begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // Outputs straight from the state register
  assign result_bit_o       = state_reg.result_bit;
  assign output_gate_flag_o = state_reg.output_gate_flag;
  assign input_gate_flag_o  = state_reg.input_gate_flag;
  assign skip_pending_o     = state_reg.skip_pending;
  assign store_pulse_o      = state_reg.store_pulse;
  assign store_data_o       = state_reg.store_data;
  assign branch_pulse_o     = state_reg.branch_pulse;
  assign return_pulse_o     = state_reg.return_pulse;
  assign flag_low_pulse_o   = state_reg.flag_low_pulse;
  assign flag_high_pulse_o  = state_reg.flag_high_pulse;

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_live(opcode_t o);
    instr_i.op == o && !state_reg.skip_pending;
  endsequence

  sequence s_skip_armed;
    s_live(SKIP_ON_ZERO) and !state_reg.result_bit;
  endsequence

  a_load_copies_input: assert property ( // RQ1
    s_live(LOAD_BIT) |=> result_bit_o == ($past(instr_i.data) && $past(input_gate_flag_o)))
    else $error("load did not copy the gated input");

  a_gate_load_source: assert property ( // RQ2
    s_live(OUTPUT_GATE) |=> output_gate_flag_o == $past(instr_i.data))
    else $error("output gate flag not loaded from source");

  a_gated_off_quiet: assert property ( // RQ3
    !output_gate_flag_o && !state_reg.skip_pending && instr_i.op != OUTPUT_GATE
      |=> !store_pulse_o && !output_gate_flag_o)
    else $error("write strobe while outputs gated off");

  a_store_inv_data: assert property ( // RQ4
    s_live(STORE_INVERTED) and output_gate_flag_o
      |=> store_pulse_o && store_data_o == !$past(result_bit_o) && $stable(result_bit_o))
    else $error("inverted store data or result bit wrong");

  a_store_true_data: assert property ( // RQ5
    s_live(STORE_BIT) and output_gate_flag_o
      |=> store_pulse_o && store_data_o == $past(result_bit_o))
    else $error("store did not write the result bit");

  a_skip_ignores_next: assert property ( // RQ6
    s_skip_armed |=> skip_pending_o ##1 (!skip_pending_o && !store_pulse_o
      && $stable(result_bit_o) && $stable(output_gate_flag_o) && !branch_pulse_o))
    else $error("instruction after skip was not ignored");

  a_no_skip_on_one: assert property ( // RQ6
    s_live(SKIP_ON_ZERO) and result_bit_o |=> !skip_pending_o)
    else $error("skip taken with result bit one");

  // Back-to-back branches give back-to-back strobes, so length is checked by origin
  a_branch_strobe: assert property ( // RQ7
    s_live(BRANCH_OP) |=> branch_pulse_o)
    else $error("branch strobe missing");

  a_branch_only_cmd: assert property ( // RQ7
    branch_pulse_o |-> $past(instr_i.op) == BRANCH_OP && !$past(skip_pending_o))
    else $error("branch strobe without a live branch");

  a_input_gate_blocks: assert property ( // RQ8
    s_live(OR_BIT) and !input_gate_flag_o |=> result_bit_o == $past(result_bit_o))
    else $error("input data passed a closed input gate");

  a_no_strobe_gated: assert property ( // RQ9
    store_pulse_o |-> $past(output_gate_flag_o))
    else $error("store strobe generated with gate zero");

  a_and_inverted: assert property ( // RQ10
    s_live(AND_INVERTED)
      |=> result_bit_o == ($past(result_bit_o) && !($past(instr_i.data) && $past(input_gate_flag_o))))
    else $error("and-inverted result wrong");

  a_or_inverted: assert property ( // RQ10
    s_live(OR_INVERTED)
      |=> result_bit_o == ($past(result_bit_o) || !($past(instr_i.data) && $past(input_gate_flag_o))))
    else $error("or-inverted result wrong");

  // Stores only drive the write port; the result must survive for the next block
  a_store_keeps_result: assert property ( // RQ5
    s_live(STORE_BIT) |=> $stable(result_bit_o))
    else $error("store changed the result bit");

  // Gating off writes must not stall instruction stepping
  a_gated_steps: assert property ( // RQ3
    s_live(FLAG_HIGH) and !output_gate_flag_o |=> flag_high_pulse_o)
    else $error("instruction not executed while gated off");

  a_return_skips: assert property ( // RQ6
    s_live(RETURN_OP) |=> return_pulse_o && skip_pending_o)
    else $error("return did not strobe and skip");

  // Gate load takes the raw bit, else a closed gate could never reopen
  a_input_gate_load: assert property ( // RQ8
    s_live(INPUT_GATE) |=> input_gate_flag_o == $past(instr_i.data))
    else $error("input gate flag not loaded from source");

endmodule : one_bit_enable_and_flow_logic

//--- prog_seq_model.sv
// Behavioural model of the outside program counter and sequencer
module prog_seq_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       branch_pulse_i,
  input  wire logic [3:0] target_i,
  output logic      [3:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ============================================================
  // Counter steps every clock; no jump hardware beyond one reload
  // reload on branch, wrap
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pc_o <= 4'h0;
    end else if (branch_pulse_i) begin
      pc_o <= target_i;
    end else begin
      pc_o <= pc_o + 4'h1; // Wraps at the top of memory
    end
  end
endmodule : prog_seq_model

//--- one_bit_enable_and_flow_logic_tb.sv
// Self-checking bench for the one-bit enable and flow logic
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module one_bit_enable_and_flow_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import one_bit_ctrl_pkg::*;

  // ============================================================
  // Signals
  logic   clk_sys_i, rst_n_i, res, out_gate, in_gate, skp, stp, std, brp, rtp, flp, fhp;
  instr_t instr_i;
  logic   [3:0] target, pc;
  int     errors, check_count;

  one_bit_enable_and_flow_logic dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .result_bit_o(res), .output_gate_flag_o(out_gate), .input_gate_flag_o(in_gate),
    .skip_pending_o(skp), .store_pulse_o(stp), .store_data_o(std),
    .branch_pulse_o(brp), .return_pulse_o(rtp), .flag_low_pulse_o(flp),
    .flag_high_pulse_o(fhp));

  prog_seq_model seq (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .branch_pulse_i(brp),
    .target_i(target), .pc_o(pc));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ============================================================
  // One instruction per cycle; outputs are looked at a half cycle later
  task automatic ex(opcode_t op, logic d);
    instr_i = '{op, d};
    @(negedge clk_sys_i);
  endtask : ex

  task automatic results;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // ============================================================
  // Scenarios
  task automatic t_load;
    ex(INPUT_GATE, 1'b1);
    ex(OUTPUT_GATE, 1'b1);
    `CHK({in_gate, out_gate}, 2'b11)
    ex(LOAD_BIT, 1'b1);
    `CHK(res, 1'b1)
    ex(LOAD_BIT, 1'b0);
    `CHK(res, 1'b0)
    ex(INPUT_GATE, 1'b0);
    ex(LOAD_BIT, 1'b1);
    `CHK(res, 1'b0)
    ex(INPUT_GATE, 1'b1);
    ex(LOAD_BIT, 1'b1);
    `CHK(res, 1'b1)
  endtask : t_load

  task automatic t_logic;
    ex(AND_INVERTED, 1'b0);
    `CHK(res, 1'b1)
    ex(AND_INVERTED, 1'b1);
    `CHK(res, 1'b0)
    ex(OR_INVERTED, 1'b0);
    `CHK(res, 1'b1)
    ex(LOAD_BIT, 1'b0);
    ex(OR_INVERTED, 1'b1);
    `CHK(res, 1'b0)
  endtask : t_logic

  // Back-to-back stores, true then inverted
  task automatic t_store;
    ex(LOAD_BIT, 1'b1);
    ex(STORE_BIT, 1'b0);
    `CHK({stp, std, res}, 3'b111)
    ex(STORE_INVERTED, 1'b0);
    `CHK({stp, std, res}, 3'b101)
    ex(FLAG_LOW, 1'b0);
    `CHK({stp, flp}, 2'b01)
  endtask : t_store

  // Gate loaded from the fed-back result; strobes must vanish
  task automatic t_gate_off;
    ex(LOAD_BIT, 1'b0);
    ex(OUTPUT_GATE, res);
    `CHK(out_gate, 1'b0)
    ex(LOAD_BIT, 1'b1);
    ex(STORE_BIT, 1'b0);
    `CHK({stp, res}, 2'b01)
    ex(STORE_INVERTED, 1'b0);
    `CHK(stp, 1'b0)
    ex(FLAG_HIGH, 1'b0);
    `CHK(fhp, 1'b1)
    ex(OUTPUT_GATE, 1'b1);
  endtask : t_gate_off

  task automatic t_skip;
    ex(LOAD_BIT, 1'b0);
    ex(SKIP_ON_ZERO, 1'b0);
    `CHK(skp, 1'b1)
    ex(STORE_BIT, 1'b0);
    `CHK({stp, skp}, 2'b00)
    ex(LOAD_BIT, 1'b1);
    ex(SKIP_ON_ZERO, 1'b0);
    `CHK(skp, 1'b0)
    ex(LOAD_BIT, 1'b0);
    `CHK(res, 1'b0)
  endtask : t_skip

  // Sequencer reload, then wrap past the top of memory
  task automatic t_branch;
    ex(BRANCH_OP, 1'b0);
    `CHK(brp, 1'b1)
    ex(FLAG_LOW, 1'b0);
    `CHK(pc, 4'h9)
    for (int i = 0; i < 7; i++) begin
      ex(FLAG_LOW, 1'b0);
    end
    `CHK(pc, 4'h0)
    ex(RETURN_OP, 1'b0);
    `CHK({rtp, skp}, 2'b11)
    ex(FLAG_LOW, 1'b0);
    `CHK(flp, 1'b0)
  endtask : t_branch

  // Remaining logic opcodes with the input gate open, then all but xnor with it closed
  task automatic t_plain_ops;
    ex(LOAD_INVERTED, 1'b0);
    `CHK(res, 1'b1)
    ex(AND_BIT, 1'b0);
    `CHK(res, 1'b0)
    ex(OR_BIT, 1'b1);
    `CHK(res, 1'b1)
    ex(XNOR_BIT, 1'b0);
    `CHK(res, 1'b0)
    ex(XNOR_BIT, 1'b0);
    `CHK(res, 1'b1)
    ex(INPUT_GATE, 1'b0);
    ex(LOAD_INVERTED, 1'b1);
    `CHK(res, 1'b1)
    ex(AND_BIT, 1'b1);
    `CHK(res, 1'b0)
    ex(OR_BIT, 1'b1);
    `CHK(res, 1'b0)
    ex(INPUT_GATE, 1'b1);
    `CHK(in_gate, 1'b1)
  endtask : t_plain_ops

  // ============================================================
  // Main sequence
  initial begin
    errors = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    target = 4'h9;
    instr_i = '{FLAG_LOW, 1'b0};
    repeat (2) @(negedge clk_sys_i);
    `CHK({res, out_gate, in_gate, skp, stp, std, brp, rtp, flp, fhp}, 10'h000)
    rst_n_i = 1'b1;
    t_load();
    t_logic();
    t_store();
    t_gate_off();
    t_skip();
    t_branch();
    t_plain_ops();
    results();
  end
endmodule : one_bit_enable_and_flow_logic_tb
